/* File: include/eis_pkg.sv */
// shared constants, types and decode helper for the external-irq / system-flag block
package eis_pkg;

  localparam logic [7:0] EIS_ADDR_SYSTEM_FLAG_IRQ_ENABLE = 8'h8E;
  localparam logic [7:0] EIS_ADDR_DMA = 8'h94;
  localparam logic [7:0] EIS_ADDR_PWR = 8'h97;
  localparam logic [7:0] EIS_ADDR_AUX = 8'hA3;
  localparam logic [7:0] EIS_ADDR_XCFG = 8'hC1;

  localparam logic [3:0] EIS_PAGE_XCFG0 = 4'h0;
  localparam logic [3:0] EIS_PAGE_XCFG1 = 4'h1;
  localparam logic [3:0] EIS_PAGE_DMA = 4'h8;
  localparam logic [3:0] EIS_PAGE_AUX = 4'h0;

  // enable register bit positions
  localparam int EIS_EN_SERIAL = 7;
  localparam int EIS_EN_RTC = 4;
  localparam int EIS_EN_BO_ONE = 2;
  localparam int EIS_EN_BO_ZERO = 1;
  localparam int EIS_EN_WDT = 0;
  // power flag register bit positions
  localparam int EIS_PF_SOFT = 7;
  localparam int EIS_PF_PIN = 6;
  localparam int EIS_PF_RTC = 4;
  localparam int EIS_PF_BO_ONE = 2;
  localparam int EIS_PF_BO_ZERO = 1;
  localparam int EIS_PF_WDT = 0;
  // auxiliary and dma bit positions
  localparam int EIS_AX_START = 7;
  localparam int EIS_AX_STOP = 6;
  localparam int EIS_DMA_PRIO_HI = 7;
  localparam int EIS_DMA_PRIO_LO = 6;
  // config page 0 / page 1 field positions
  localparam int EIS_X0_ONE_SEL = 6;
  localparam int EIS_X0_ZERO_SEL = 4;
  localparam int EIS_X1_ONE_SEL = 7;
  localparam int EIS_X1_ZERO_SEL = 6;
  localparam int EIS_X1_TWO_SEL = 4;
  localparam int EIS_XF_TWO = 2;
  localparam int EIS_XF_ONE = 1;
  localparam int EIS_XF_ZERO = 0;

  // implemented (readable) bits of each register
  localparam logic [7:0] EIS_MASK_SYSTEM_FLAG_IRQ_ENABLE = 8'h97;
  localparam logic [7:0] EIS_MASK_DMA = 8'hEF;
  localparam logic [7:0] EIS_MASK_PWR = 8'hD7;
  localparam logic [7:0] EIS_MASK_AUX_FLAG = 8'hC0;
  localparam logic [7:0] EIS_MASK_AUX_CTRL = 8'h0F;
  localparam logic [7:0] EIS_MASK_XCFG = 8'hF7;

  localparam logic [7:0] EIS_RST_SYSTEM_FLAG_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] EIS_RST_DMA = 8'h00;
  localparam logic [7:0] EIS_RST_PWR = 8'h00;
  localparam logic [7:0] EIS_RST_AUX = 8'h00;
  localparam logic [7:0] EIS_RST_XCFG = 8'h00;
  localparam logic [7:0] EIS_RST_RDATA = 8'h00;

  // clock/6 sample tick: counter runs 0..5
  localparam logic [2:0] EIS_DIV6_LAST = 3'h5;
  localparam logic [2:0] EIS_DIV6_RST = 3'h0;
  // external irq pins are active low, so they idle high
  localparam logic EIS_PIN_IDLE = 1'b1;

  typedef enum logic [1:0] {
    EIS_FLT_OFF = 2'b00,
    EIS_FLT_SYS = 2'b01,
    EIS_FLT_DIV6 = 2'b10,
    EIS_FLT_BRG = 2'b11
  } eis_flt_mode_t;

  function automatic logic eis_hit(input logic [7:0] a, input logic [3:0] p,
                                   input logic [7:0] ra, input logic [3:0] rp,
                                   input logic any_page);
    return (a == ra) && (any_page || (p == rp));
  endfunction

endpackage

/* File: rtl/eis_pin_filter.sv */
// three-sample glitch filter for one external interrupt input
`timescale 1ns/1ps
module eis_pin_filter
  import eis_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_din,
  input wire eis_flt_mode_t i_mode,
  input wire logic i_tick_div6,
  input wire logic i_tick_brg,
  output logic o_dout
);

  logic [1:0] hist_r;
  logic out_r;
  logic sample;
  logic agree;

  always_comb begin
    case (i_mode)
      EIS_FLT_OFF: sample = 1'b0;
      EIS_FLT_SYS: sample = 1'b1;
      EIS_FLT_DIV6: sample = i_tick_div6;
      EIS_FLT_BRG: sample = i_tick_brg;
      default: sample = 1'b0;
    endcase
  end

  // outside bypass, output moves only when the new sample matches the two before it
  assign agree = (i_din == hist_r[0]) && (i_din == hist_r[1]);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hist_r <= {2{EIS_PIN_IDLE}};
      out_r <= EIS_PIN_IDLE;
    end else if (i_ce) begin
      if (i_mode == EIS_FLT_OFF) begin
        out_r <= i_din;
        hist_r <= {2{i_din}};
      end else if (sample) begin
        hist_r <= {hist_r[0], i_din};
        if (agree) begin
          out_r <= i_din;
        end
      end
    end
  end

  assign o_dout = out_r;

  property p_filter_bypass;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && i_mode == EIS_FLT_OFF) |=> (o_dout == $past(i_din));
  endproperty
  a_filter_bypass: assert property (p_filter_bypass)
    else $error("bypassed filter did not follow its input");

  property p_filter_sys_three;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && i_mode == EIS_FLT_SYS && $changed(i_din) && i_din != o_dout) |=> $stable(o_dout);
  endproperty
  a_filter_sys_three: assert property (p_filter_sys_three)
    else $error("filter output moved on a single new sample");

endmodule

/* File: rtl/eis_sysflag_top.sv */
// external irq routing, glitch filters and system-flag enables, flags and request
`timescale 1ns/1ps
module eis_sysflag_top
  import eis_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [3:0] i_sfr_page,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic [7:0] i_irq_zero_pins,
  input wire logic [7:0] i_irq_one_pins,
  input wire logic [3:0] i_irq_two_pins,
  input wire logic i_serial_baudgen_overflow,
  input wire logic i_soft_reset_evt,
  input wire logic i_pin_reset_evt,
  input wire logic i_rtc_overflow,
  input wire logic i_brownout_one_trip,
  input wire logic i_brownout_zero_trip,
  input wire logic i_watchdog_overflow,
  input wire logic i_bus_start_det,
  input wire logic i_bus_stop_det,
  input wire logic i_system_flag_global_enable,
  output logic o_ext_irq_in_zero_n,
  output logic o_ext_irq_in_one_n,
  output logic o_ext_irq_in_two_n,
  output logic o_system_flag_irq,
  output logic [1:0] o_dma_group_prio,
  output logic [3:0] o_timer_aux_ctrl
);

  // register state
  logic [7:0] system_flag_irq_enable_r;
  logic [7:0] dma_r;
  logic [7:0] pwr_r;
  logic [7:0] aux_r;
  logic [7:0] xcfg0_r;
  logic [7:0] xcfg1_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic [2:0] div6_r;
  logic [19:0] pins_meta_r;
  logic [19:0] pins_r;
  logic [1:0] bo_meta_r;
  logic [1:0] bo_r;

  logic [7:0] system_flag_irq_enable_nxt;
  logic [7:0] dma_nxt;
  logic [7:0] pwr_nxt;
  logic [7:0] aux_nxt;
  logic [7:0] xcfg0_nxt;
  logic [7:0] xcfg1_nxt;
  logic [7:0] rdata_nxt;
  logic irq_nxt;
  logic [2:0] div6_nxt;

  // address decode
  logic hit_system_flag_irq_enable;
  logic hit_dma;
  logic hit_pwr;
  logic hit_aux;
  logic hit_xcfg0;
  logic hit_xcfg1;
  logic wr_system_flag_irq_enable;
  logic wr_dma;
  logic wr_pwr;
  logic wr_aux;
  logic wr_xcfg0;
  logic wr_xcfg1;

  assign hit_system_flag_irq_enable = eis_hit(i_sfr_addr, i_sfr_page, EIS_ADDR_SYSTEM_FLAG_IRQ_ENABLE, EIS_PAGE_XCFG0, 1'b1);
  assign hit_pwr = eis_hit(i_sfr_addr, i_sfr_page, EIS_ADDR_PWR, EIS_PAGE_XCFG0, 1'b1);
  assign hit_dma = eis_hit(i_sfr_addr, i_sfr_page, EIS_ADDR_DMA, EIS_PAGE_DMA, 1'b0);
  assign hit_aux = eis_hit(i_sfr_addr, i_sfr_page, EIS_ADDR_AUX, EIS_PAGE_AUX, 1'b0);
  assign hit_xcfg0 = eis_hit(i_sfr_addr, i_sfr_page, EIS_ADDR_XCFG, EIS_PAGE_XCFG0, 1'b0);
  assign hit_xcfg1 = eis_hit(i_sfr_addr, i_sfr_page, EIS_ADDR_XCFG, EIS_PAGE_XCFG1, 1'b0);

  assign wr_system_flag_irq_enable = i_sfr_wr && hit_system_flag_irq_enable;
  assign wr_dma = i_sfr_wr && hit_dma;
  assign wr_pwr = i_sfr_wr && hit_pwr;
  assign wr_aux = i_sfr_wr && hit_aux;
  assign wr_xcfg0 = i_sfr_wr && hit_xcfg0;
  assign wr_xcfg1 = i_sfr_wr && hit_xcfg1;

  // plain read/write registers; reserved bits (bits 6, 5, 3 in the enable, bit 3 in the config pages, bit 4 in dma) are never stored, so a stray one is harmless
  assign system_flag_irq_enable_nxt = wr_system_flag_irq_enable ? (i_sfr_wdata & EIS_MASK_SYSTEM_FLAG_IRQ_ENABLE) : system_flag_irq_enable_r;
  assign dma_nxt = wr_dma ? (i_sfr_wdata & EIS_MASK_DMA) : dma_r;
  assign xcfg0_nxt = wr_xcfg0 ? (i_sfr_wdata & EIS_MASK_XCFG) : xcfg0_r;
  assign xcfg1_nxt = wr_xcfg1 ? (i_sfr_wdata & EIS_MASK_XCFG) : xcfg1_r;

  // power flags: hardware sets, software writes one to clear, set wins
  logic [7:0] pwr_set;
  logic [7:0] pwr_clr;
  always_comb begin
    pwr_set = 8'h00;
    pwr_set[EIS_PF_SOFT] = i_soft_reset_evt;
    pwr_set[EIS_PF_PIN] = i_pin_reset_evt;
    pwr_set[EIS_PF_RTC] = i_rtc_overflow;
    pwr_set[EIS_PF_BO_ONE] = bo_r[1];
    pwr_set[EIS_PF_BO_ZERO] = bo_r[0];
    pwr_set[EIS_PF_WDT] = i_watchdog_overflow;
  end
  // write-one-to-clear; writing zero leaves every flag alone, bits 5 and 3 ignored
  assign pwr_clr = wr_pwr ? (i_sfr_wdata & EIS_MASK_PWR) : 8'h00;
  assign pwr_nxt = pwr_set | (pwr_r & ~pwr_clr);

  // bus start/stop flags: cleared by writing zero, writing one has no effect
  logic [7:0] aux_set;
  logic [7:0] aux_clr;
  logic [7:0] aux_ctrl_nxt;
  always_comb begin
    aux_set = 8'h00;
    aux_set[EIS_AX_START] = i_bus_start_det;
    aux_set[EIS_AX_STOP] = i_bus_stop_det;
  end
  assign aux_clr = wr_aux ? (~i_sfr_wdata & EIS_MASK_AUX_FLAG) : 8'h00;
  assign aux_ctrl_nxt = wr_aux ? (i_sfr_wdata & EIS_MASK_AUX_CTRL) : (aux_r & EIS_MASK_AUX_CTRL);
  assign aux_nxt = ((aux_set | (aux_r & ~aux_clr)) & EIS_MASK_AUX_FLAG) | aux_ctrl_nxt;

  // read mux; unmapped addresses return zero
  assign rdata_nxt = hit_system_flag_irq_enable ? system_flag_irq_enable_r :
                     hit_pwr ? pwr_r :
                     hit_dma ? dma_r :
                     hit_aux ? aux_r :
                     hit_xcfg0 ? xcfg0_r :
                     hit_xcfg1 ? xcfg1_r : 8'h00;

  // pin routing from the synchronised port pins
  logic [7:0] zero_pins_s;
  logic [7:0] one_pins_s;
  logic [3:0] two_pins_s;
  logic [2:0] irq0_sel;
  logic [2:0] irq1_sel;
  logic [1:0] irq2_sel;
  logic irq0_raw;
  logic irq1_raw;
  logic irq2_raw;

  assign zero_pins_s = pins_r[7:0];
  assign one_pins_s = pins_r[15:8];
  assign two_pins_s = pins_r[19:16];
  assign irq1_sel = {xcfg1_r[EIS_X1_ONE_SEL], xcfg0_r[EIS_X0_ONE_SEL+:2]};
  assign irq0_sel = {xcfg1_r[EIS_X1_ZERO_SEL], xcfg0_r[EIS_X0_ZERO_SEL+:2]};
  assign irq2_sel = xcfg1_r[EIS_X1_TWO_SEL+:2];
  assign irq0_raw = zero_pins_s[irq0_sel];
  assign irq1_raw = one_pins_s[irq1_sel];
  assign irq2_raw = two_pins_s[irq2_sel];

  // filter modes, high bit from page 1, low bit from page 0
  eis_flt_mode_t flt0_mode;
  eis_flt_mode_t flt1_mode;
  eis_flt_mode_t flt2_mode;
  assign flt0_mode = eis_flt_mode_t'({xcfg1_r[EIS_XF_ZERO], xcfg0_r[EIS_XF_ZERO]});
  assign flt1_mode = eis_flt_mode_t'({xcfg1_r[EIS_XF_ONE], xcfg0_r[EIS_XF_ONE]});
  assign flt2_mode = eis_flt_mode_t'({xcfg1_r[EIS_XF_TWO], xcfg0_r[EIS_XF_TWO]});

  logic tick_div6;
  assign tick_div6 = (div6_r == EIS_DIV6_LAST);
  assign div6_nxt = tick_div6 ? EIS_DIV6_RST : div6_r + 3'h1;

  // system-flag request: or of the rtc, brown-out, watchdog and bus flags, each anded with its enable; soft and pin reset flags not included
  logic serial_req;
  logic pwr_req;
  logic sf_req;
  assign serial_req = system_flag_irq_enable_r[EIS_EN_SERIAL] &&
                      (aux_r[EIS_AX_START] || aux_r[EIS_AX_STOP]);
  assign pwr_req = (system_flag_irq_enable_r[EIS_EN_RTC] && pwr_r[EIS_PF_RTC]) ||
                   (system_flag_irq_enable_r[EIS_EN_BO_ONE] && pwr_r[EIS_PF_BO_ONE]) ||
                   (system_flag_irq_enable_r[EIS_EN_BO_ZERO] && pwr_r[EIS_PF_BO_ZERO]) ||
                   (system_flag_irq_enable_r[EIS_EN_WDT] && pwr_r[EIS_PF_WDT]);
  assign sf_req = serial_req || pwr_req;
  assign irq_nxt = i_system_flag_global_enable && sf_req;

  // pins and brown-out detectors come from outside this clock: two flops first
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins_meta_r <= {20{EIS_PIN_IDLE}};
      pins_r <= {20{EIS_PIN_IDLE}};
      bo_meta_r <= 2'h0;
      bo_r <= 2'h0;
    end else if (i_ce) begin
      pins_meta_r <= {i_irq_two_pins, i_irq_one_pins, i_irq_zero_pins};
      pins_r <= pins_meta_r;
      bo_meta_r <= {i_brownout_one_trip, i_brownout_zero_trip};
      bo_r <= bo_meta_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      system_flag_irq_enable_r <= EIS_RST_SYSTEM_FLAG_IRQ_ENABLE;
      dma_r <= EIS_RST_DMA;
      pwr_r <= EIS_RST_PWR;
      aux_r <= EIS_RST_AUX;
      xcfg0_r <= EIS_RST_XCFG;
      xcfg1_r <= EIS_RST_XCFG;
    end else if (i_ce) begin
      system_flag_irq_enable_r <= system_flag_irq_enable_nxt;
      dma_r <= dma_nxt;
      pwr_r <= pwr_nxt;
      aux_r <= aux_nxt;
      xcfg0_r <= xcfg0_nxt;
      xcfg1_r <= xcfg1_nxt;
    end
  end

  // read data is held until the next read strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= EIS_RST_RDATA;
      irq_r <= 1'b0;
      div6_r <= EIS_DIV6_RST;
    end else if (i_ce) begin
      if (i_sfr_rd) begin
        rdata_r <= rdata_nxt;
      end
      irq_r <= irq_nxt;
      div6_r <= div6_nxt;
    end
  end

  // the filtered level, not the raw pin, goes on to edge/level detection
  eis_pin_filter u_flt_zero (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_din(irq0_raw),
    .i_mode(flt0_mode),
    .i_tick_div6(tick_div6),
    .i_tick_brg(i_serial_baudgen_overflow),
    .o_dout(o_ext_irq_in_zero_n)
  );

  eis_pin_filter u_flt_one (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_din(irq1_raw),
    .i_mode(flt1_mode),
    .i_tick_div6(tick_div6),
    .i_tick_brg(i_serial_baudgen_overflow),
    .o_dout(o_ext_irq_in_one_n)
  );

  eis_pin_filter u_flt_two (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_din(irq2_raw),
    .i_mode(flt2_mode),
    .i_tick_div6(tick_div6),
    .i_tick_brg(i_serial_baudgen_overflow),
    .o_dout(o_ext_irq_in_two_n)
  );

  assign o_sfr_rdata = rdata_r;
  assign o_system_flag_irq = irq_r;
  assign o_dma_group_prio = {dma_r[EIS_DMA_PRIO_HI], dma_r[EIS_DMA_PRIO_LO]};
  assign o_timer_aux_ctrl = aux_r[3:0];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_route0_steady;
    (i_ce && $stable(irq0_sel)) [*3];
  endsequence

  property p_route_zero;
    s_route0_steady |-> (irq0_raw == $past(i_irq_zero_pins[irq0_sel], 2));
  endproperty
  a_route_zero: assert property (p_route_zero)
    else $error("irq zero not routed from the selected pin");

  property p_route_one;
    (i_ce && $stable(irq1_sel)) [*3] |-> (irq1_raw == $past(i_irq_one_pins[irq1_sel], 2));
  endproperty
  a_route_one: assert property (p_route_one)
    else $error("irq one not routed from the selected pin");

  property p_rtc_w1c;
    (i_ce && wr_pwr && i_sfr_wdata[EIS_PF_RTC] && !i_rtc_overflow) |=> !pwr_r[EIS_PF_RTC];
  endproperty
  a_rtc_w1c: assert property (p_rtc_w1c)
    else $error("rtc flag not cleared by writing one");

  property p_rtc_write0;
    (i_ce && wr_pwr && !i_sfr_wdata[EIS_PF_RTC] && pwr_r[EIS_PF_RTC]) |=> pwr_r[EIS_PF_RTC];
  endproperty
  a_rtc_write0: assert property (p_rtc_write0)
    else $error("rtc flag lost on a write of zero");

  // held a second cycle unless software cleared it in the cycle after the event
  property p_soft_set;
    (i_ce && i_soft_reset_evt) |=> pwr_r[EIS_PF_SOFT] ##1
      (pwr_r[EIS_PF_SOFT] || $past(i_ce && wr_pwr && i_sfr_wdata[EIS_PF_SOFT]));
  endproperty
  a_soft_set: assert property (p_soft_set)
    else $error("soft reset flag not set or not held");

  property p_wdt_set_wins;
    (i_ce && i_watchdog_overflow && wr_pwr && i_sfr_wdata[EIS_PF_WDT]) |=> pwr_r[EIS_PF_WDT];
  endproperty
  a_wdt_set_wins: assert property (p_wdt_set_wins)
    else $error("watchdog event lost against a clear");

  property p_start_clear0;
    (i_ce && wr_aux && !i_sfr_wdata[EIS_AX_START] && !i_bus_start_det)
      |=> !aux_r[EIS_AX_START];
  endproperty
  a_start_clear0: assert property (p_start_clear0)
    else $error("start flag not cleared by writing zero");

  property p_serial_gate;
    (i_ce && !system_flag_irq_enable_r[EIS_EN_SERIAL] && !pwr_req) |=> !o_system_flag_irq;
  endproperty
  a_serial_gate: assert property (p_serial_gate)
    else $error("serial detect flag requested while disabled");

  property p_sf_request;
    i_ce |=> (o_system_flag_irq ==
              $past(i_system_flag_global_enable && |(pwr_r & system_flag_irq_enable_r & 8'h17)
                    | (i_system_flag_global_enable && serial_req)));
  endproperty
  a_sf_request: assert property (p_sf_request)
    else $error("system-flag request does not match flags and enables");

  property p_dma_prio;
    (i_ce && wr_dma) |=> (o_dma_group_prio == $past(i_sfr_wdata[7:6]));
  endproperty
  a_dma_prio: assert property (p_dma_prio)
    else $error("dma group priority not taken from bits 7 and 6");

endmodule

/* File: sim/eis_tb.sv */
// self-checking bench for the external-irq routing and system-flag block
`timescale 1ns/1ps
module testbench;
  import eis_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] page = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] zp = 8'hFF;
  logic [7:0] op = 8'hFF;
  logic [3:0] tp = 4'hF;
  logic brg = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [1:0] bev = 2'h0;
  logic gen = 1'b0;
  logic [2:0] saw = 3'h0;
  logic saw_clr = 1'b0;
  logic ce = 1'b1;
  logic [7:0] rdata;
  logic irq0_n, irq1_n, irq2_n, sf_irq;
  logic [1:0] prio;
  logic [3:0] aux;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] pfm [6] = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h02, 8'h01};
  logic [7:0] enm [6] = '{8'h00, 8'h00, 8'h10, 8'h04, 8'h02, 8'h01};

  eis_sysflag_top u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
    .i_sfr_addr(addr), .i_sfr_page(page), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .i_irq_zero_pins(zp), .i_irq_one_pins(op), .i_irq_two_pins(tp),
    .i_serial_baudgen_overflow(brg), .i_soft_reset_evt(ev[0]), .i_pin_reset_evt(ev[1]),
    .i_rtc_overflow(ev[2]), .i_brownout_one_trip(ev[3]), .i_brownout_zero_trip(ev[4]),
    .i_watchdog_overflow(ev[5]), .i_bus_start_det(bev[0]), .i_bus_stop_det(bev[1]),
    .i_system_flag_global_enable(gen),
    .o_ext_irq_in_zero_n(irq0_n), .o_ext_irq_in_one_n(irq1_n),
    .o_ext_irq_in_two_n(irq2_n), .o_system_flag_irq(sf_irq),
    .o_dma_group_prio(prio), .o_timer_aux_ctrl(aux)
  );

  initial begin
    forever #2 i_clk = ~i_clk;
  end

  // sticky record of any filtered output going low, cleared by the filter test
  always @(posedge i_clk) begin
    cycles++;
    saw <= saw_clr ? 3'h0 : (saw | ~{irq2_n, irq1_n, irq0_n});
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // strobe lowered one negedge later; next access waits a further negedge
  task automatic swr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
    @(negedge i_clk);
    addr = a;
    page = p;
    wdata = d;
    wr = 1'b1;
    @(negedge i_clk);
    wr = 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [3:0] p,
                      input logic [7:0] exp);
    @(negedge i_clk);
    addr = a;
    page = p;
    rd = 1'b1;
    @(negedge i_clk);
    rd = 1'b0;
    chk(nm, exp, rdata);
  endtask

  task automatic t_reset();
    rchk("enable", EIS_ADDR_SYSTEM_FLAG_IRQ_ENABLE, 4'h3, 8'h00);
    rchk("power", EIS_ADDR_PWR, 4'h5, 8'h00);
    rchk("dma", EIS_ADDR_DMA, EIS_PAGE_DMA, 8'h00);
    rchk("aux", EIS_ADDR_AUX, EIS_PAGE_AUX, 8'h00);
    rchk("cfg0", EIS_ADDR_XCFG, EIS_PAGE_XCFG0, 8'h00);
    rchk("cfg1", EIS_ADDR_XCFG, EIS_PAGE_XCFG1, 8'h00);
    rchk("unmapped", 8'h80, 4'h0, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_access();
    swr(EIS_ADDR_DMA, 4'h0, 8'hFF);
    rchk("dma wrong page", EIS_ADDR_DMA, EIS_PAGE_DMA, 8'h00);
    swr(EIS_ADDR_SYSTEM_FLAG_IRQ_ENABLE, 4'h9, 8'hF7);
    rchk("enable mask", EIS_ADDR_SYSTEM_FLAG_IRQ_ENABLE, 4'h0, 8'h97);
    swr(EIS_ADDR_AUX, EIS_PAGE_AUX, 8'h3F);
    rchk("aux mask", EIS_ADDR_AUX, EIS_PAGE_AUX, 8'h0F);
    chk("aux out", 8'h0F, {4'h0, aux});
    swr(EIS_ADDR_XCFG, EIS_PAGE_XCFG0, 8'h5D);
    swr(EIS_ADDR_XCFG, EIS_PAGE_XCFG1, 8'hA2);
    rchk("cfg0 rb", EIS_ADDR_XCFG, EIS_PAGE_XCFG0, 8'h55);
    rchk("cfg1 rb", EIS_ADDR_XCFG, EIS_PAGE_XCFG1, 8'hA2);
    swr(EIS_ADDR_DMA, EIS_PAGE_DMA, 8'hFF);
    rchk("dma mask", EIS_ADDR_DMA, EIS_PAGE_DMA, 8'hEF);
    for (int v = 0; v < 4; v++) begin
      swr(EIS_ADDR_DMA, EIS_PAGE_DMA, {v[1:0], 6'h00});
      wt(1);
      chk("prio", {6'h0, v[1:0]}, {6'h0, prio});
    end
    swr(EIS_ADDR_SYSTEM_FLAG_IRQ_ENABLE, 4'h0, 8'h00);
    swr(EIS_ADDR_AUX, EIS_PAGE_AUX, 8'h00);
    swr(EIS_ADDR_XCFG, EIS_PAGE_XCFG0, 8'h00);
    swr(EIS_ADDR_XCFG, EIS_PAGE_XCFG1, 8'h00);
    $display("test access done");
  endtask

  task automatic t_flags();
    @(negedge i_clk);
    gen = 1'b1;
    for (int i = 0; i < 6; i++) begin
      swr(EIS_ADDR_SYSTEM_FLAG_IRQ_ENABLE, 4'h0, 8'h00);
      @(negedge i_clk);
      ev[i] = 1'b1;
      @(negedge i_clk);
      ev[i] = 1'b0;
      wt(4);
      rchk("flag set", EIS_ADDR_PWR, 4'h2, pfm[i]);
      chk("irq masked", 8'h00, {7'h0, sf_irq});
      swr(EIS_ADDR_SYSTEM_FLAG_IRQ_ENABLE, 4'h0, enm[i]);
      wt(3);
      chk("irq enabled", {7'h0, |enm[i]}, {7'h0, sf_irq});
      @(negedge i_clk);
      gen = 1'b0;
      wt(3);
      chk("irq global off", 8'h00, {7'h0, sf_irq});
      @(negedge i_clk);
      gen = 1'b1;
      // zeros at the flag bit leave it set; ones elsewhere must not touch it
      swr(EIS_ADDR_PWR, 4'h0, ~pfm[i] & 8'hF7);
      rchk("flag kept", EIS_ADDR_PWR, 4'h0, pfm[i]);
      swr(EIS_ADDR_PWR, 4'h0, pfm[i]);
      rchk("flag cleared", EIS_ADDR_PWR, 4'h0, 8'h00);
    end
    $display("test flags done");
  endtask

  task automatic t_bus();
    logic [7:0] am;
    for (int j = 0; j < 2; j++) begin
      am = 8'h80 >> j;
      swr(EIS_ADDR_SYSTEM_FLAG_IRQ_ENABLE, 4'h0, 8'h00);
      @(negedge i_clk);
      bev[j] = 1'b1;
      @(negedge i_clk);
      bev[j] = 1'b0;
      wt(3);
      rchk("bus flag", EIS_ADDR_AUX, EIS_PAGE_AUX, am);
      chk("bus irq off", 8'h00, {7'h0, sf_irq});
      swr(EIS_ADDR_SYSTEM_FLAG_IRQ_ENABLE, 4'h0, 8'h80);
      wt(3);
      chk("bus irq on", 8'h01, {7'h0, sf_irq});
      swr(EIS_ADDR_AUX, EIS_PAGE_AUX, am);
      rchk("bus flag kept", EIS_ADDR_AUX, EIS_PAGE_AUX, am);
      swr(EIS_ADDR_AUX, EIS_PAGE_AUX, 8'h00);
      rchk("bus flag clr", EIS_ADDR_AUX, EIS_PAGE_AUX, 8'h00);
      wt(3);
      chk("bus irq gone", 8'h00, {7'h0, sf_irq});
    end
    swr(EIS_ADDR_SYSTEM_FLAG_IRQ_ENABLE, 4'h0, 8'h00);
    $display("test bus flags done");
  endtask

  task automatic t_route();
    logic [2:0] s;
    for (int k = 0; k < 8; k++) begin
      s = k[2:0];
      swr(EIS_ADDR_XCFG, EIS_PAGE_XCFG0, {s[1:0], s[1:0], 4'h0});
      swr(EIS_ADDR_XCFG, EIS_PAGE_XCFG1, {s[2], s[2], s[1:0], 4'h0});
      @(negedge i_clk);
      zp = ~(8'h01 << s);
      op = ~(8'h01 << s);
      tp = ~(4'h1 << s[1:0]);
      wt(6);
      chk("route low", 8'h00, {5'h0, irq2_n, irq1_n, irq0_n});
      @(negedge i_clk);
      zp = 8'h01 << s;
      op = 8'h01 << s;
      tp = 4'h1 << s[1:0];
      wt(6);
      chk("route high", 8'h07, {5'h0, irq2_n, irq1_n, irq0_n});
    end
    swr(EIS_ADDR_XCFG, EIS_PAGE_XCFG0, 8'h00);
    swr(EIS_ADDR_XCFG, EIS_PAGE_XCFG1, 8'h00);
    @(negedge i_clk);
    {zp, op, tp} = 20'hFFFFF;
    $display("test route done");
  endtask

  task automatic mode(input logic [1:0] m);
    swr(EIS_ADDR_XCFG, EIS_PAGE_XCFG0, m[0] ? 8'h07 : 8'h00);
    swr(EIS_ADDR_XCFG, EIS_PAGE_XCFG1, m[1] ? 8'h07 : 8'h00);
    wt(30);
    saw_clr = 1'b1;
    wt(1);
    saw_clr = 1'b0;
  endtask

  // with the enable low nothing moves, not even a write strobe or an event
  task automatic t_ce();
    @(negedge i_clk);
    ce = 1'b0;
    swr(EIS_ADDR_SYSTEM_FLAG_IRQ_ENABLE, 4'h0, 8'h10);
    ev[5] = 1'b1;
    wt(2);
    ev[5] = 1'b0;
    ce = 1'b1;
    rchk("ce enable", EIS_ADDR_SYSTEM_FLAG_IRQ_ENABLE, 4'h0, 8'h00);
    rchk("ce flag", EIS_ADDR_PWR, 4'h0, 8'h00);
    $display("test clock enable done");
  endtask

  // all selected pins low for n cycles, then idle, then settle
  task automatic glitch(input int n, input int w);
    @(negedge i_clk);
    {zp, op, tp} = 20'h00000;
    wt(n);
    {zp, op, tp} = 20'hFFFFF;
    wt(w);
  endtask

  task automatic t_filter();
    mode(2'b00);
    glitch(1, 8);
    chk("bypass", 8'h07, {5'h0, saw});
    mode(2'b01);
    glitch(2, 10);
    chk("sys short", 8'h00, {5'h0, saw});
    glitch(4, 10);
    chk("sys long", 8'h07, {5'h0, saw});
    mode(2'b10);
    glitch(8, 30);
    chk("div6 short", 8'h00, {5'h0, saw});
    glitch(24, 30);
    chk("div6 long", 8'h07, {5'h0, saw});
    mode(2'b11);
    glitch(30, 1);
    chk("brg no tick", 8'h00, {5'h0, saw});
    {zp, op, tp} = 20'h00000;
    repeat (5) begin
      @(negedge i_clk);
      brg = 1'b1;
      @(negedge i_clk);
      brg = 1'b0;
    end
    wt(3);
    chk("brg ticks", 8'h07, {5'h0, saw});
    {zp, op, tp} = 20'hFFFFF;
    mode(2'b00);
    $display("test filter done");
  endtask

  initial begin
    fork
      begin
        wt(10);
        i_rst_n = 1'b1;
        wt(3);
        t_reset();
        swr(EIS_ADDR_AUX, EIS_PAGE_AUX, 8'h00);
        t_ce();
        t_access();
        t_flags();
        t_bus();
        t_route();
        t_filter();
      end
      begin
        // whole run needs about eight hundred cycles
        wait (cycles == 20000);
        num_errors++;
        $display("[ERR] run length expected below %0d seen %0d", 20000, cycles);
      end
    join_any
    final_report();
  end
endmodule
